// ### pkg/btau_pkg.sv
/*
  btau_pkg: constants and enumerations for the branch target address unit.
  assumes nothing of its surroundings; shared by both design files.
*/
package btau_pkg;
  localparam int unsigned OPCODE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned PHYS_W = 20;
  localparam int unsigned SEG_SHIFT = 4;
  localparam int unsigned OPERAND_MAX = 5;
  localparam int unsigned CNT_W = 3;
  localparam int unsigned INSTR_COUNT = 101;
  localparam int unsigned GROUP_COUNT = 27;
  localparam int unsigned GROUP_W = 5;
  localparam int unsigned REG_IDX_W = 3;
  localparam int unsigned NUM_GREGS = 8;
  localparam logic [WORD_W-1:0] SEG_RESET = 16'hffff;
  localparam logic [WORD_W-1:0] OFS_RESET = 16'h0000;
  // branch target method, chosen by the execution unit after decode
  typedef enum logic [2:0] {
    BTAU_TGT_NONE,
    BTAU_TGT_FAR_DIRECT,
    BTAU_TGT_REL8,
    BTAU_TGT_REL16,
    BTAU_TGT_REG_IND,
    BTAU_TGT_MEM_IND16,
    BTAU_TGT_MEM_IND32
  } btau_tgt_e;
  // operand source class reported alongside each operand
  typedef enum logic [1:0] {
    BTAU_SRC_REG,
    BTAU_SRC_IMM,
    BTAU_SRC_IO,
    BTAU_SRC_MEM
  } btau_src_e;
endpackage

// ### design/btau_phys_addr.sv
/*
  btau_phys_addr: forms a physical address from segment base and offset.
  assumes both inputs are unsigned and come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module btau_phys_addr (
  input wire logic [btau_pkg::WORD_W-1:0] seg_i,
  input wire logic [btau_pkg::WORD_W-1:0] ofs_i,
  output logic [btau_pkg::PHYS_W-1:0] phys_o
);
  // carry above bit 19 wraps, as a 20-bit bus would
  assign phys_o = btau_pkg::PHYS_W'({seg_i, 4'h0}) + btau_pkg::PHYS_W'(ofs_i);
endmodule
`default_nettype wire

// ### design/btau_branch_target_unit.sv
/*
  btau_branch_target_unit: instruction address generation and op-code framing.
  assumes the fetch unit presents one code byte per valid pulse in order, and
  the execution unit supplies operand length, target method and register file.
*/
`timescale 1ns/1ps
`default_nettype none
module btau_branch_target_unit (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_data_i,
  output logic byte_ready_o,
  input wire logic [btau_pkg::CNT_W-1:0] operand_len_i,
  input wire logic [btau_pkg::GROUP_W-1:0] group_i,
  input wire logic [1:0] operand_src_i,
  input wire logic [2:0] jump_op_i,
  input wire logic jump_op_valid_i,
  input wire logic [btau_pkg::REG_IDX_W-1:0] reg_sel_i,
  input wire logic [btau_pkg::NUM_GREGS*btau_pkg::WORD_W-1:0] gregs_i,
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_data_i,
  output logic [btau_pkg::OPCODE_W-1:0] opcode_o,
  output logic opcode_valid_o,
  output logic [btau_pkg::OPCODE_W-1:0] operand_byte_o,
  output logic [btau_pkg::CNT_W-1:0] operand_idx_o,
  output logic operand_valid_o,
  output logic [1:0] operand_class_o,
  output logic instr_done_o,
  output logic group_err_o,
  output logic [btau_pkg::WORD_W-1:0] code_segment_base_o,
  output logic [btau_pkg::WORD_W-1:0] instruction_offset_counter_o,
  output logic [btau_pkg::PHYS_W-1:0] fetch_addr_o,
  output logic redirect_o
);
  typedef enum logic [1:0] {
    BTAU_ST_OPCODE,
    BTAU_ST_OPERAND,
    BTAU_ST_WAIT_TGT,
    BTAU_ST_WAIT_MEM
  } btau_state_e;

  btau_state_e state_r;
  logic [btau_pkg::WORD_W-1:0] code_segment_base_r;
  logic [btau_pkg::WORD_W-1:0] instruction_offset_counter_r;
  logic [btau_pkg::CNT_W-1:0] len_r;
  logic [btau_pkg::CNT_W-1:0] idx_r;
  logic [39:0] imm_r;
  logic [2:0] pend_op_r;
  logic [btau_pkg::OPCODE_W-1:0] opcode_r;
  logic opcode_valid_r;
  logic [btau_pkg::OPCODE_W-1:0] operand_byte_r;
  logic [btau_pkg::CNT_W-1:0] operand_idx_r;
  logic operand_valid_r;
  logic [1:0] operand_class_r;
  logic instr_done_r;
  logic group_err_r;
  logic redirect_r;
  logic take_byte;
  logic [btau_pkg::CNT_W-1:0] len_clip;
  logic [btau_pkg::WORD_W-1:0] disp;
  logic [btau_pkg::WORD_W-1:0] greg_val;

  // fetch is only stalled while a branch target is still being formed
  assign byte_ready_o = (state_r == BTAU_ST_OPCODE) || (state_r == BTAU_ST_OPERAND);
  assign take_byte = byte_valid_i && byte_ready_o;
  // longer requests are clipped to the legal maximum
  assign len_clip = (operand_len_i > btau_pkg::CNT_W'(btau_pkg::OPERAND_MAX)) ?
                    btau_pkg::CNT_W'(btau_pkg::OPERAND_MAX) : operand_len_i;
  assign greg_val = gregs_i[reg_sel_i*btau_pkg::WORD_W +: btau_pkg::WORD_W];

  // method is read live in the target cycle; the pending copy lags by one edge
  function automatic logic btau_tgt_is_rel8(input logic [2:0] op);
    return op == 3'(btau_pkg::BTAU_TGT_REL8);
  endfunction

  always_comb begin
    disp = btau_pkg::WORD_W'(0);
    if (btau_tgt_is_rel8(jump_op_i)) begin
      disp = {{8{imm_r[7]}}, imm_r[7:0]};
    end else begin
      disp = imm_r[15:0];
    end
  end

  // framing state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= BTAU_ST_OPCODE;
      len_r <= '0;
      idx_r <= '0;
      pend_op_r <= 3'h0;
    end else begin
      unique case (state_r)
        BTAU_ST_OPCODE: begin
          if (take_byte) begin
            idx_r <= '0;
            len_r <= len_clip;
            if (len_clip != '0) begin
              state_r <= BTAU_ST_OPERAND;
            end else if (jump_op_valid_i) begin
              state_r <= BTAU_ST_WAIT_TGT;
            end
          end
        end
        BTAU_ST_OPERAND: begin
          if (take_byte) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r + 3'h1 == len_r) begin
              state_r <= jump_op_valid_i ? BTAU_ST_WAIT_TGT : BTAU_ST_OPCODE;
            end
          end
        end
        BTAU_ST_WAIT_TGT: begin
          pend_op_r <= jump_op_i;
          if (jump_op_i == 3'(btau_pkg::BTAU_TGT_MEM_IND16) ||
              jump_op_i == 3'(btau_pkg::BTAU_TGT_MEM_IND32)) begin
            state_r <= BTAU_ST_WAIT_MEM;
          end else begin
            state_r <= BTAU_ST_OPCODE;
          end
        end
        BTAU_ST_WAIT_MEM: begin
          if (mem_valid_i) begin
            state_r <= BTAU_ST_OPCODE;
          end
        end
      endcase
    end
  end

  // operand byte capture, little-endian
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      imm_r <= 40'h0;
    end else if (take_byte && state_r == BTAU_ST_OPERAND) begin
      imm_r[idx_r*8 +: 8] <= byte_data_i;
    end else if (take_byte) begin
      imm_r <= 40'h0;
    end
  end

  // instruction address update: the sequential increment takes priority over jumps
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_segment_base_r <= btau_pkg::SEG_RESET;
      instruction_offset_counter_r <= btau_pkg::OFS_RESET;
      redirect_r <= 1'b0;
    end else begin
      redirect_r <= 1'b0;
      if (take_byte) begin
        instruction_offset_counter_r <= instruction_offset_counter_r + 16'h0001;
      end else if (state_r == BTAU_ST_WAIT_TGT) begin
        redirect_r <= jump_op_i != 3'(btau_pkg::BTAU_TGT_NONE) &&
                      jump_op_i != 3'(btau_pkg::BTAU_TGT_MEM_IND16) &&
                      jump_op_i != 3'(btau_pkg::BTAU_TGT_MEM_IND32);
        unique case (jump_op_i)
          3'(btau_pkg::BTAU_TGT_FAR_DIRECT): begin
            instruction_offset_counter_r <= imm_r[15:0];
            code_segment_base_r <= imm_r[31:16];
          end
          3'(btau_pkg::BTAU_TGT_REL8): begin
            instruction_offset_counter_r <= instruction_offset_counter_r + disp;
          end
          3'(btau_pkg::BTAU_TGT_REL16): begin
            instruction_offset_counter_r <= instruction_offset_counter_r + disp;
          end
          3'(btau_pkg::BTAU_TGT_REG_IND): begin
            instruction_offset_counter_r <= greg_val;
          end
          default: begin
          end
        endcase
      end else if (state_r == BTAU_ST_WAIT_MEM && mem_valid_i) begin
        redirect_r <= 1'b1;
        instruction_offset_counter_r <= mem_data_i[15:0];
        if (pend_op_r == 3'(btau_pkg::BTAU_TGT_MEM_IND32)) begin
          code_segment_base_r <= mem_data_i[31:16];
        end
      end
    end
  end

  // decode outputs toward the execution unit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opcode_r <= 8'h00;
      opcode_valid_r <= 1'b0;
      operand_byte_r <= 8'h00;
      operand_idx_r <= '0;
      operand_valid_r <= 1'b0;
      operand_class_r <= 2'h0;
      instr_done_r <= 1'b0;
      group_err_r <= 1'b0;
    end else begin
      opcode_valid_r <= 1'b0;
      operand_valid_r <= 1'b0;
      instr_done_r <= 1'b0;
      if (take_byte && state_r == BTAU_ST_OPCODE) begin
        opcode_r <= byte_data_i;
        opcode_valid_r <= 1'b1;
        operand_class_r <= operand_src_i;
        // group codes past the last class are flagged; framing and any jump still go ahead
        group_err_r <= group_i >= btau_pkg::GROUP_W'(btau_pkg::GROUP_COUNT);
        instr_done_r <= (len_clip == '0) && !jump_op_valid_i;
      end else if (take_byte) begin
        operand_byte_r <= byte_data_i;
        operand_idx_r <= idx_r;
        operand_valid_r <= 1'b1;
        instr_done_r <= (idx_r + 3'h1 == len_r) && !jump_op_valid_i;
      end else if (redirect_r) begin
        instr_done_r <= 1'b1;
      end
    end
  end

  assign opcode_o = opcode_r;
  assign opcode_valid_o = opcode_valid_r;
  assign operand_byte_o = operand_byte_r;
  assign operand_idx_o = operand_idx_r;
  assign operand_valid_o = operand_valid_r;
  assign operand_class_o = operand_class_r;
  assign instr_done_o = instr_done_r;
  assign group_err_o = group_err_r;
  assign redirect_o = redirect_r;
  assign code_segment_base_o = code_segment_base_r;
  assign instruction_offset_counter_o = instruction_offset_counter_r;

  btau_phys_addr u_phys (
    .seg_i(code_segment_base_r),
    .ofs_i(instruction_offset_counter_r),
    .phys_o(fetch_addr_o)
  );
endmodule
`default_nettype wire

// ### tb/btau_checker.sv
/* btau_checker: port checks on the branch target unit.
   assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module btau_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_data_i,
  input wire logic byte_ready_o,
  input wire logic [4:0] group_i,
  input wire logic [2:0] jump_op_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [127:0] gregs_i,
  input wire logic [7:0] opcode_o,
  input wire logic opcode_valid_o,
  input wire logic instr_done_o,
  input wire logic group_err_o,
  input wire logic [15:0] code_segment_base_o,
  input wire logic [15:0] instruction_offset_counter_o,
  input wire logic [19:0] fetch_addr_o,
  input wire logic redirect_o
);
  wire logic [15:0] seg = code_segment_base_o;
  wire logic [15:0] ofs = instruction_offset_counter_o;
  wire logic take = byte_valid_i && byte_ready_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_ofs_step: assert property (take |=> ofs == $past(ofs) + 16'h0001)
    else $error("offset step wrong");
  a_phys_addr: assert property (fetch_addr_o == {seg, 4'h0} + {4'h0, ofs})
    else $error("fetch address wrong");
  a_opcode_data: assert property (opcode_valid_o |-> $past(take) && opcode_o == $past(byte_data_i))
    else $error("op-code byte wrong");
  a_group_err: assert property (opcode_valid_o |-> group_err_o == ($past(group_i) >= 5'h1b))
    else $error("group flag wrong");
  a_reg_load: assert property ($fell(byte_ready_o) && jump_op_i == 3'h4 |=>
    ofs == $past(gregs_i[16*reg_sel_i +: 16]) && $stable(seg))
    else $error("register target wrong");
  a_rel_keep: assert property ($fell(byte_ready_o) && jump_op_i inside {3'h2, 3'h3} |=>
    $stable(seg) && redirect_o)
    else $error("relative branch moved segment");
  a_redir_done: assert property (redirect_o |=> instr_done_o && !redirect_o)
    else $error("done missing after redirect");
  a_wait_hold: assert property (!byte_ready_o |=> $stable(ofs) || redirect_o)
    else $error("offset moved while waiting");
  c_redirect: cover property (redirect_o);
  c_group_err: cover property (opcode_valid_o && group_err_o);
  c_reg_load: cover property ($fell(byte_ready_o) && jump_op_i == 3'h4);
  c_far_load: cover property ($fell(byte_ready_o) && jump_op_i == 3'h1);
endmodule
bind btau_branch_target_unit btau_checker u_chk (.*);
`default_nettype wire

// ### tb/btau_fetch_model.sv
/* btau_fetch_model: fetch side, hands out code bytes and memory targets.
   assumes a byte is taken at a rising edge while ready is high. */
`timescale 1ns/1ps
`default_nettype none
module btau_fetch_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic mem_valid_o,
  output logic [31:0] mem_data_o
);
  logic [7:0] q[$];
  int gap = 0;
  int idle = 0;
  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
    mem_valid_o = 1'b0;
    mem_data_o = 32'h0;
  end
  // idle data toggles so a stale byte never passes for a fresh one
  always @(posedge clk_i) begin
    if (valid_o && ready_i) idle = gap;
    if (!valid_o || ready_i) begin
      valid_o <= idle == 0 && q.size() > 0;
      data_o <= (idle == 0 && q.size() > 0) ? q.pop_front() : ~data_o;
      if (idle > 0) idle--;
    end
  end
  task automatic mem_answer(input logic [31:0] d);
    repeat (2) @(posedge clk_i);
    mem_valid_o <= 1'b1;
    mem_data_o <= d;
    @(posedge clk_i);
    mem_valid_o <= 1'b0;
    mem_data_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
/* testbench: runs the unit against the fetch model and checks addresses.
   assumes design, checker and model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic jump_op_valid_i = 1'b0;
  logic [2:0] operand_len_i = 3'h0, jump_op_i = 3'h0, reg_sel_i = 3'h0;
  logic [4:0] group_i = 5'h00;
  logic [1:0] operand_src_i = 2'h0;
  logic [127:0] gregs_i = 128'h0;
  wire logic byte_valid_i, byte_ready_o, mem_valid_i, opcode_valid_o, operand_valid_o;
  wire logic instr_done_o, group_err_o, redirect_o;
  wire logic [7:0] byte_data_i, opcode_o, operand_byte_o;
  wire logic [31:0] mem_data_i;
  wire logic [2:0] operand_idx_o;
  wire logic [1:0] operand_class_o;
  wire logic [15:0] code_segment_base_o, instruction_offset_counter_o;
  wire logic [19:0] fetch_addr_o;
  wire logic [31:0] seg = {16'h0, code_segment_base_o};
  wire logic [31:0] ofs = {16'h0, instruction_offset_counter_o};
  logic [15:0] e_ofs = 16'h0, e_seg = 16'hffff;
  int miscompares = 0, checks = 0;
  btau_branch_target_unit dut (.*);
  btau_fetch_model fm (.clk_i, .ready_i(byte_ready_o), .valid_o(byte_valid_i),
    .data_o(byte_data_i), .mem_valid_o(mem_valid_i), .mem_data_o(mem_data_i));
  always #5 clk_i = ~clk_i;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [39:0] opr, input int n,
      input logic [2:0] jop, input logic [31:0] md);
    @(posedge clk_i);
    operand_len_i <= 3'(n);
    jump_op_valid_i <= jop != 3'h0;
    jump_op_i <= jop;
    @(negedge clk_i);
    fm.q.push_back(op);
    for (int i = 0; i < n; i++) fm.q.push_back(opr[8*i +: 8]);
    for (int i = 0; i < 40 && jop > 3'h4 && byte_ready_o !== 1'b0; i++) @(negedge clk_i);
    if (jop > 3'h4) fm.mem_answer(md);
    for (int i = 0; i < 60 && instr_done_o !== 1'b1; i++) @(negedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic t_seq();
    for (int k = 0; k < 4; k++) begin
      operand_src_i <= 2'(k);
      group_i <= 5'h17 + 5'(k);
      run(8'h90 + 8'(k), 40'h5544332211, k + 2, 3'h0, 32'h0);
      e_ofs += 16'(k + 3);
      cmp(32'(opcode_o), 32'(8'h90 + 8'(k)));
      cmp(32'(operand_byte_o), 32'(8'h11 * 8'(k + 2)));
      cmp(32'(operand_idx_o), 32'(k + 1));
      cmp(32'(operand_class_o), 32'(k));
      cmp(32'(group_err_o), 32'h0);
      cmp(ofs, 32'(e_ofs));
    end
  endtask
  task automatic t_far();
    group_i <= 5'h1b;
    run(8'hea, 40'h0020001234, 4, 3'h1, 32'h0);
    e_ofs = 16'h1234;
    e_seg = 16'h2000;
    cmp(seg, 32'(e_seg));
    cmp(ofs, 32'(e_ofs));
    cmp(32'(fetch_addr_o), 32'h21234);
    cmp(32'(group_err_o), 32'h1);
  endtask
  task automatic t_rel();
    fm.gap = 2;
    run(8'heb, 40'h80, 1, 3'h2, 32'h0);
    e_ofs += 16'hff82;
    cmp(ofs, 32'(e_ofs));
    run(8'he9, 40'hf000, 2, 3'h3, 32'h0);
    e_ofs += 16'hf003;
    cmp(ofs, 32'(e_ofs));
    cmp(seg, 32'(e_seg));
    fm.gap = 0;
  endtask
  task automatic t_ind();
    for (int k = 0; k < 8; k++) gregs_i[16*k +: 16] <= 16'ha000 + 16'(k);
    reg_sel_i <= 3'h6;
    run(8'hff, 40'h0, 0, 3'h4, 32'h0);
    cmp(ofs, 32'ha006);
    cmp(seg, 32'(e_seg));
    run(8'hff, 40'h0, 2, 3'h5, 32'h5555_4321);
    cmp(ofs, 32'h4321);
    cmp(seg, 32'(e_seg));
    run(8'hff, 40'h0, 2, 3'h6, 32'h3000_0abc);
    cmp(ofs, 32'h0abc);
    cmp(seg, 32'h3000);
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    cmp(32'(fetch_addr_o), 32'h000ffff0);
    t_seq();
    t_far();
    t_rel();
    t_ind();
    test_done();
  end
  // far above the hundred or so cycles the scenarios need
  initial begin
    repeat (2000) @(posedge clk_i);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
